// >>> hdl/prfz_pkg.sv
// Package with the register map, field positions and states of the freeze controller.
//
// Summary of operation
// R1: Region outputs held constant throughout reconfiguration.
// R2: Hold logic lives here, in static logic.
// R3: Selector mode passes a constant value instead.
// R4: Register mode stops enable, keeping last values.
// R5: Region inputs pass through, never frozen.
// R6: Outputs invalid until programming done and reset.
// R7: Memory guard sits in region, takes clear.
// R8: Clear raised before programming starts.
// R9: Clear dropped only after programming completes.
// R10: Region guard delay register cleared by clear.
// R11: Memory clock gated off during whole reconfiguration; here re-enabled as the region reset begins.
// R12: All personas share one identical port set.
// R13: One controller instance per reconfigurable region.
// R14: Completion input from configuration engine ends programming.
// R15: Hold from before start until reset released.
package prfz_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_FRZVAL = 8'h04;
    localparam logic [7:0] ADDR_RSTLEN = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    // Control register fields.
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_BIT  = 1;

    // Status register fields.
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_FROZEN_BIT = 1;
    localparam int STAT_CLEAR_BIT  = 2;
    localparam int STAT_RESET_BIT  = 3;
    localparam int STAT_DONE_BIT   = 4;
    localparam int STAT_STATE_LSB  = 8;

    // Reset values.
    localparam logic [31:0] FRZVAL_RESET = 32'h0000_0000;
    localparam logic [15:0] RSTLEN_RESET = 16'h0010;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Sequence states.
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_FREEZE  = 3'b001,
        ST_PROGRAM = 3'b010,
        ST_RESET   = 3'b011,
        ST_SETTLE  = 3'b100
    } prfz_state_e;

endpackage

// >>> hdl/prfz_hold_if.sv
// Interface between the sequencer and the output hold stage.
`timescale 1ns/10ps
`default_nettype none

interface prfz_hold_if #(
    parameter int WIDTH = 32
);
    logic             freeze;
    logic             hold_mode;
    logic [WIDTH-1:0] const_val;
    logic [WIDTH-1:0] region_out;
    logic [WIDTH-1:0] held;

    modport ctrl (
        output freeze,
        output hold_mode,
        output const_val,
        output region_out,
        input  held
    );

    modport stage (
        input  freeze,
        input  hold_mode,
        input  const_val,
        input  region_out,
        output held
    );
endinterface

`default_nettype wire

// >>> hdl/prfz_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module prfz_sync (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta;
    logic stage2;
    logic stage3;

    // The first stage feeds only the second, so a metastable level is never decoded.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta   <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta   <= async_i;
            stage2 <= meta;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                sync_o <= stage3;
            end
        end
    end
endmodule

`default_nettype wire

// >>> hdl/prfz_hold.sv
// Output hold stage placed between the region outputs and the static logic.
`timescale 1ns/10ps
`default_nettype none

module prfz_hold (
    input  wire logic  clk_i,
    input  wire logic  rstn_i,
    prfz_hold_if.stage hif
);
    // Selector mode picks the constant, register mode simply keeps the last word.
    wire sel_const = hif.freeze && !hif.hold_mode;
    wire load_en   = !hif.freeze;

    // Registered so that a glitch on the region side never reaches the receivers.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            hif.held <= '0;
        end else if (sel_const) begin
            hif.held <= hif.const_val;                     // see R3
        end else if (load_en) begin
            hif.held <= hif.region_out;                    // see R4
        end
    end
endmodule

`default_nettype wire

// >>> hdl/prfz_ctrl.sv
// Static-side freeze controller for one reconfigurable region, with AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module prfz_ctrl #(
    parameter int REGION_W = 32
) (
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    // AXI4-Lite slave.
    input  wire logic [7:0]          s_axi_awaddr_i,
    input  wire logic                s_axi_awvalid_i,
    output logic                     s_axi_awready_o,
    input  wire logic [31:0]         s_axi_wdata_i,
    input  wire logic [3:0]          s_axi_wstrb_i,
    input  wire logic                s_axi_wvalid_i,
    output logic                     s_axi_wready_o,
    output logic [1:0]               s_axi_bresp_o,
    output logic                     s_axi_bvalid_o,
    input  wire logic                s_axi_bready_i,
    input  wire logic [7:0]          s_axi_araddr_i,
    input  wire logic                s_axi_arvalid_i,
    output logic                     s_axi_arready_o,
    output logic [31:0]              s_axi_rdata_o,
    output logic [1:0]               s_axi_rresp_o,
    output logic                     s_axi_rvalid_o,
    input  wire logic                s_axi_rready_i,
    // Configuration engine.
    output logic                     prog_start_o,
    input  wire logic                prog_done_i,
    // Reconfigurable region.
    input  wire logic [REGION_W-1:0] region_out_i,
    output logic [REGION_W-1:0]      region_held_o,
    output logic                     region_freeze_o,
    output logic                     region_clear_o,
    output logic                     region_rst_o,
    output logic                     mem_clk_en_o
);
    // Elaboration check on the region width.
    if (REGION_W < 1 || REGION_W > 32) begin : g_bad_width
        $error("REGION_W must lie between 1 and 32");
    end

    prfz_pkg::prfz_state_e state;
    prfz_pkg::prfz_state_e next_state;

    logic        hold_mode;
    logic [31:0] frz_val;
    logic [15:0] rst_len;
    logic [15:0] rst_cnt;
    logic        done_flag;
    logic        prog_done_s;

    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // Completion of the configuration engine arrives from outside this clock.
    prfz_sync u_done_sync (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i (prog_done_i),
        .sync_o  (prog_done_s)
    );

    prfz_hold_if #(.WIDTH(REGION_W)) hif ();

    // Region inputs are not touched; only its outputs pass the hold stage.
    assign hif.freeze     = region_freeze_o;                // see R1, R13
    assign hif.hold_mode  = hold_mode;
    assign hif.const_val  = frz_val[REGION_W-1:0];
    assign hif.region_out = region_out_i;                   // see R5, R12
    assign region_held_o  = hif.held;

    // The hold stage stays on the static side of the region boundary.
    prfz_hold u_hold (                                      // see R2
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .hif    (hif)
    );

    // Write decode; a write happens once address and data are both latched.
    wire wr_fire   = aw_got && w_got && !s_axi_bvalid_o;
    wire wr_ctrl   = wr_fire && (aw_addr == prfz_pkg::ADDR_CTRL);
    wire wr_frzval = wr_fire && (aw_addr == prfz_pkg::ADDR_FRZVAL);
    wire wr_rstlen = wr_fire && (aw_addr == prfz_pkg::ADDR_RSTLEN);
    wire wr_status = wr_fire && (aw_addr == prfz_pkg::ADDR_STATUS);
    wire wr_hit    = wr_ctrl || wr_frzval || wr_rstlen || wr_status;
    wire start_req = wr_ctrl && w_strb[0]
                     && w_data[prfz_pkg::CTRL_START_BIT];
    wire idle      = (state == prfz_pkg::ST_IDLE);
    wire rst_over  = (rst_cnt == 16'h0000);

    // Sequencer transitions.
    always_comb begin
        next_state = state;
        case (state)
            prfz_pkg::ST_IDLE: begin
                if (start_req) begin
                    next_state = prfz_pkg::ST_FREEZE;
                end
            end
            prfz_pkg::ST_FREEZE: begin
                // One cycle with freeze, clear and gate settled before programming.
                next_state = prfz_pkg::ST_PROGRAM;          // see R8
            end
            prfz_pkg::ST_PROGRAM: begin
                if (prog_done_s) begin
                    next_state = prfz_pkg::ST_RESET;        // see R14
                end
            end
            prfz_pkg::ST_RESET: begin
                if (rst_over) begin
                    next_state = prfz_pkg::ST_SETTLE;
                end
            end
            prfz_pkg::ST_SETTLE: begin
                next_state = prfz_pkg::ST_IDLE;
            end
            default: begin
                next_state = prfz_pkg::ST_IDLE;
            end
        endcase
    end

    // Freeze spans start to one cycle past the region reset release.
    wire next_freeze = (next_state != prfz_pkg::ST_IDLE);   // see R15
    // Clear and clock gate cover the freeze cycle and the programming window.
    wire next_clear  = (next_state == prfz_pkg::ST_FREEZE)
                       || (next_state == prfz_pkg::ST_PROGRAM);
    wire next_rst    = (next_state == prfz_pkg::ST_RESET);

    // State and region-side control outputs.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state           <= prfz_pkg::ST_IDLE;
            region_freeze_o <= 1'b0;
            region_clear_o  <= 1'b0;
            region_rst_o    <= 1'b0;
            mem_clk_en_o    <= 1'b1;
            prog_start_o    <= 1'b0;
        end else begin
            state           <= next_state;
            region_freeze_o <= next_freeze;                 // see R6
            region_clear_o  <= next_clear;                  // see R9
            region_rst_o    <= next_rst;
            mem_clk_en_o    <= !next_clear;                 // see R11
            prog_start_o    <= (next_state == prfz_pkg::ST_PROGRAM);
        end
    end

    // Region reset length counter, loaded on entry to the reset phase.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rst_cnt <= 16'h0000;
        end else if (state != prfz_pkg::ST_RESET) begin
            rst_cnt <= rst_len;
        end else if (!rst_over) begin
            rst_cnt <= rst_cnt - 16'h0001;
        end
    end

    // Software registers; mode and constant only change while idle.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            hold_mode <= 1'b0;
            frz_val   <= prfz_pkg::FRZVAL_RESET;
            rst_len   <= prfz_pkg::RSTLEN_RESET;
        end else begin
            if (wr_ctrl && idle && w_strb[0]) begin
                hold_mode <= w_data[prfz_pkg::CTRL_MODE_BIT];
            end
            if (wr_frzval && idle) begin
                for (int i = 0; i < 4; i++) begin
                    if (w_strb[i]) begin
                        frz_val[i*8 +: 8] <= w_data[i*8 +: 8];
                    end
                end
            end
            if (wr_rstlen) begin
                if (w_strb[0]) begin
                    rst_len[7:0] <= w_data[7:0];
                end
                if (w_strb[1]) begin
                    rst_len[15:8] <= w_data[15:8];
                end
            end
        end
    end

    // Sticky completion flag; a new completion beats a write-one clear.
    wire done_set = (state == prfz_pkg::ST_SETTLE);
    wire done_clr = wr_status && w_strb[0]
                    && w_data[prfz_pkg::STAT_DONE_BIT];

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            done_flag <= 1'b0;
        end else if (done_set) begin
            done_flag <= 1'b1;
        end else if (done_clr) begin
            done_flag <= 1'b0;
        end
    end

    // Write channel: address and data are latched independently, either order.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            aw_got          <= 1'b0;
            w_got           <= 1'b0;
            aw_addr         <= 8'h00;
            w_data          <= 32'h0000_0000;
            w_strb          <= 4'h0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= prfz_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_got          <= 1'b1;
                aw_addr         <= {s_axi_awaddr_i[7:2], 2'b00};
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_got          <= 1'b1;
                w_data         <= s_axi_wdata_i;
                w_strb         <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_fire) begin
                aw_got         <= 1'b0;
                w_got          <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_hit ? prfz_pkg::RESP_OKAY
                                         : prfz_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o  <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
            end
        end
    end

    // Read decode; status shows the sequencer's live state.
    wire [7:0]  rd_addr = {s_axi_araddr_i[7:2], 2'b00};
    wire [31:0] status_word = {
        21'h00_0000, state,
        3'b000, done_flag, region_rst_o, region_clear_o,
        region_freeze_o, !idle
    };
    wire rd_ctrl   = (rd_addr == prfz_pkg::ADDR_CTRL);
    wire rd_frzval = (rd_addr == prfz_pkg::ADDR_FRZVAL);
    wire rd_rstlen = (rd_addr == prfz_pkg::ADDR_RSTLEN);
    wire rd_status = (rd_addr == prfz_pkg::ADDR_STATUS);
    wire rd_hit    = rd_ctrl || rd_frzval || rd_rstlen || rd_status;
    wire [31:0] rd_word =
        rd_ctrl   ? {30'h0000_0000, hold_mode, 1'b0} :
        rd_frzval ? frz_val :
        rd_rstlen ? {16'h0000, rst_len} :
        rd_status ? status_word : 32'h0000_0000;

    // Read channel: one read outstanding, answer one cycle after the address.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= prfz_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= rd_word;
            s_axi_rresp_o   <= rd_hit ? prfz_pkg::RESP_OKAY
                                      : prfz_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// >>> sim/prfz_ctrl_chk.sv
// Concurrent checks on the freeze controller ports, bound to the controller.
`timescale 1ns/10ps
`default_nettype none

module prfz_ctrl_chk #(
    parameter int REGION_W = 32
) (
    input wire logic                clk_i,
    input wire logic                rstn_i,
    input wire logic                s_axi_awready_o,
    input wire logic                s_axi_bvalid_o,
    input wire logic                s_axi_arready_o,
    input wire logic                s_axi_rvalid_o,
    input wire logic                prog_start_o,
    input wire logic                prog_done_i,
    input wire logic [REGION_W-1:0] region_out_i,
    input wire logic [REGION_W-1:0] region_held_o,
    input wire logic                region_freeze_o,
    input wire logic                region_clear_o,
    input wire logic                region_rst_o,
    input wire logic                mem_clk_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // The region is isolated, and its memories guarded, before programming.
    sequence s_isolated;
        region_freeze_o && region_clear_o && !mem_clk_en_o;
    endsequence

    // Clear and clock gate are let go just as the region reset begins.
    sequence s_release;
        !region_clear_o && mem_clk_en_o && region_rst_o;
    endsequence

    chk_isolate_first: assert property ($rose(region_freeze_o) |-> s_isolated ##1 prog_start_o)
        else $error("programming not preceded by isolation");
    chk_prog_isolated: assert property (prog_start_o |-> s_isolated)
        else $error("programming while region not isolated");
    chk_release_done: assert property ($fell(prog_start_o) |-> s_release ##0 $past(prog_done_i, 2))
        else $error("clear released before completion");
    chk_frozen_reset: assert property (region_rst_o |-> region_freeze_o)
        else $error("outputs passed while region in reset");
    chk_settle_one: assert property ($fell(region_rst_o) |-> region_freeze_o ##1 !region_freeze_o)
        else $error("freeze not released one cycle after reset");
    chk_held_frozen: assert property (region_freeze_o && $past(region_freeze_o) && $past(region_freeze_o, 2) |-> $stable(region_held_o))
        else $error("held outputs moved while frozen");
    chk_held_pass: assert property (!region_freeze_o && !$past(region_freeze_o) && !$past(region_freeze_o, 2) && $past(rstn_i) && $past(rstn_i, 2) |-> region_held_o == $past(region_out_i))
        else $error("held outputs do not follow region");
    chk_write_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
        else $error("write address accepted during response");
    chk_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address accepted during response");
endmodule

bind prfz_ctrl prfz_ctrl_chk #(.REGION_W(REGION_W)) chk_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .prog_start_o(prog_start_o),
    .prog_done_i(prog_done_i), .region_out_i(region_out_i),
    .region_held_o(region_held_o), .region_freeze_o(region_freeze_o),
    .region_clear_o(region_clear_o), .region_rst_o(region_rst_o),
    .mem_clk_en_o(mem_clk_en_o));

`default_nettype wire

// >>> sim/prfz_region_model.sv
// Model of the configuration engine and of the region with its memory guard.
`timescale 1ns/10ps
`default_nettype none

module prfz_region_model #(
    parameter int W   = 16,
    parameter int LAT = 40
) (
    input  wire logic   clk_i,
    input  wire logic   rstn_i,
    input  wire logic   prog_start_i,
    input  wire logic   region_clear_i,
    input  wire logic   region_rst_i,
    input  wire logic   mem_clk_en_i,
    output logic        prog_done_o,
    output logic [W-1:0] region_out_o,
    output int          spur_o
);
    int         wait_n;
    logic [1:0] ce_delay;

    // Engine answers LAT+1 cycles after the request and holds done until it drops.
    always @(posedge clk_i) begin
        if (!rstn_i || !prog_start_i) begin
            wait_n <= 0;
            prog_done_o <= 1'b0;
        end else if (wait_n == LAT) begin
            prog_done_o <= 1'b1;
        end else begin
            wait_n <= wait_n + 1;
        end
    end

    // Outputs toggle as garbage while rewritten or reset, else a count runs.
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            region_out_o <= '0;
        end else if (prog_start_i || region_rst_i) begin
            region_out_o <= ~region_out_o;
        end else begin
            region_out_o <= region_out_o + 1'b1;
        end
    end

    // Enable delay line is wiped at once by the clear, whatever the clock does.
    always @(posedge clk_i or posedge region_clear_i) begin
        if (region_clear_i) begin
            ce_delay <= 2'b00;
        end else begin
            ce_delay <= {ce_delay[0], 1'b1};
        end
    end

    // A memory write landing during programming would corrupt preloaded data.
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            spur_o <= 0;
        end else if (mem_clk_en_i && ce_delay[1] && prog_start_i) begin
            spur_o <= spur_o + 1;
        end
    end
endmodule

`default_nettype wire

// >>> sim/tb_top.sv
// Testbench of the freeze controller driven over its register bus.
`timescale 1ns/10ps
`default_nettype none

`define chk_eq(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) begin \
            fails++; \
            $display("wrong value %s expected %h seen %h", nm, ex, got); \
        end \
    end

module tb_top;
    localparam int W = 16;
    logic         clk_i, rstn_i;
    logic [7:0]   awaddr, araddr;
    logic [31:0]  wdata, rdata;
    logic [1:0]   bresp, rresp;
    logic         awvalid, awready, wvalid, wready, bvalid, bready;
    logic         arvalid, arready, rvalid, rready;
    logic         prog_start, prog_done, freeze, clear, rst, mem_en;
    logic [W-1:0] reg_out, held, hv;
    int           spur, rst_cyc = 0, rst_base, fails, n_tests, m;

    prfz_ctrl #(.REGION_W(W)) dut_u (
        .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .prog_start_o(prog_start),
        .prog_done_i(prog_done), .region_out_i(reg_out),
        .region_held_o(held), .region_freeze_o(freeze),
        .region_clear_o(clear), .region_rst_o(rst), .mem_clk_en_o(mem_en));

    prfz_region_model #(.W(W), .LAT(40)) region_u (
        .clk_i(clk_i), .rstn_i(rstn_i), .prog_start_i(prog_start),
        .region_clear_i(clear), .region_rst_i(rst), .mem_clk_en_i(mem_en),
        .prog_done_o(prog_done), .region_out_o(reg_out), .spur_o(spur));

    // Free-running 40 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Counts the cycles the region reset stands.
    always @(posedge clk_i) begin
        if (rst === 1'b1) rst_cyc <= rst_cyc + 1;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Write with both channels offered at once; bready is raised with them.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int i;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        if (i == 100) begin
            fails++;
            stop_test();
        end
        `chk_eq("bresp", er, bresp)
    endtask

    // Read; data and response are taken at the edge that sees rvalid.
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        int i;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        if (i == 100) begin
            fails++;
            stop_test();
        end
        `chk_eq("rdata", ed, rdata)
        `chk_eq("rresp", er, rresp)
    endtask

    // Waits, bounded, until programming (sel 0) or freeze (sel 1) reads v.
    task automatic wait_lvl(input int sel, input logic v);
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge clk_i);
            if ((sel == 0 ? prog_start : freeze) === v) break;
        end
        if (i == 300) begin
            fails++;
            stop_test();
        end
    endtask

    // Held outputs follow the region one cycle late when not frozen.
    task automatic chk_pass();
        logic [W-1:0] v;
        @(posedge clk_i);
        v = reg_out;
        #1;
        `chk_eq("held pass", v, held)
    endtask

    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, rstn_i, fails, n_tests} = '0;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        `chk_eq("held reset", 16'h0000, held)
        `chk_eq("clk en reset", 1'b1, mem_en)
        axi_rd(prfz_pkg::ADDR_FRZVAL, prfz_pkg::FRZVAL_RESET, 2'b00);
        axi_rd(prfz_pkg::ADDR_RSTLEN, 32'h0000_0010, 2'b00);
        axi_rd(prfz_pkg::ADDR_STATUS, 32'h0000_0000, 2'b00);
        axi_rd(8'h10, 32'h0000_0000, prfz_pkg::RESP_SLVERR);
        axi_wr(8'h10, 32'h0000_FFFF, prfz_pkg::RESP_SLVERR);
        chk_pass();
        // Constant selector first, then holding of the last value.
        for (m = 0; m < 2; m++) begin
            axi_wr(prfz_pkg::ADDR_FRZVAL, 32'h5A5A_C3C3, 2'b00);
            axi_wr(prfz_pkg::ADDR_RSTLEN, 32'h0000_0003, 2'b00);
            rst_base = rst_cyc;
            axi_wr(prfz_pkg::ADDR_CTRL, {30'h0, m[0], 1'b1}, 2'b00);
            wait_lvl(0, 1'b1);
            `chk_eq("isolated", 3'b110, {freeze, clear, mem_en})
            `chk_eq("hold kind", m == 0, held === 16'hC3C3)
            hv = held;
            axi_wr(prfz_pkg::ADDR_FRZVAL, 32'h0000_1111, 2'b00);
            axi_rd(prfz_pkg::ADDR_STATUS, 32'h0000_0207, 2'b00);
            `chk_eq("held frozen", hv, held)
            wait_lvl(1, 1'b0);
            `chk_eq("reset cycles", 4, rst_cyc - rst_base)
            `chk_eq("spurious writes", 0, spur)
            axi_rd(prfz_pkg::ADDR_FRZVAL, 32'h5A5A_C3C3, 2'b00);
            axi_rd(prfz_pkg::ADDR_STATUS, 32'h0000_0010, 2'b00);
            axi_wr(prfz_pkg::ADDR_STATUS, 32'h0000_0010, 2'b00);
            axi_rd(prfz_pkg::ADDR_STATUS, 32'h0000_0000, 2'b00);
            chk_pass();
        end
        stop_test();
    end
endmodule

`default_nettype wire
